//--- inc/rqp_pkg.sv
package rqp_pkg;
  // Register offsets (byte addresses on the host bus)
  localparam logic [7:0] RQP_OFS_QCTRL     = 8'h82;
  localparam logic [7:0] RQP_OFS_RDPTR     = 8'h86;
  localparam logic [7:0] RQP_OFS_AGE_LIM   = 8'h8c;
  localparam logic [7:0] RQP_OFS_BYTE_LIM  = 8'h8e;
  localparam logic [7:0] RQP_OFS_IRQ_FLAGS = 8'h92;

  // Read pointer control fields
  localparam int RQP_PTR_AUTO_BIT   = 14;
  localparam int RQP_PTR_SAMPLE_BIT = 12;
  localparam int RQP_PTR_ORDER_BIT  = 11;
  localparam int RQP_PTR_IDX_W      = 11;

  // Queue control fields
  localparam int RQP_QC_AGE_EN_BIT  = 7;
  localparam int RQP_QC_BYTE_EN_BIT = 6;
  localparam int RQP_QC_BURST_BIT   = 3;

  // Interrupt flag field
  localparam int RQP_IRQ_RX_BIT = 13;

  // Reset values and age limit maximum
  localparam logic [15:0] RQP_RST_AGE_LIM  = 16'h0000;
  localparam logic [15:0] RQP_RST_BYTE_LIM = 16'h0000;
  localparam logic [15:0] RQP_AGE_LIM_MAX  = 16'hcfff;

  // Access widths of a data read
  localparam logic [1:0] RQP_SIZE_BYTE  = 2'h0;
  localparam logic [1:0] RQP_SIZE_WORD  = 2'h1;
  localparam logic [1:0] RQP_SIZE_DWORD = 2'h2;

  // Timing
  localparam int RQP_CLK_PERIOD_NS   = 4;
  localparam int RQP_AGE_TICK_NS     = 1000;
  localparam int RQP_AGE_TICK_CYC    = RQP_AGE_TICK_NS / RQP_CLK_PERIOD_NS;
  localparam int RQP_SAMPLE_SLOW_NS  = 8;
  localparam int RQP_SAMPLE_FAST_NS  = 4;
  localparam int RQP_SAMPLE_SLOW_CYC =
    (RQP_SAMPLE_SLOW_NS + RQP_CLK_PERIOD_NS - 1) / RQP_CLK_PERIOD_NS;
  localparam int RQP_SAMPLE_FAST_CYC =
    (RQP_SAMPLE_FAST_NS / RQP_CLK_PERIOD_NS < 1) ? 1 : RQP_SAMPLE_FAST_NS / RQP_CLK_PERIOD_NS;

  typedef enum logic [0:0] {RQP_WR_IDLE, RQP_WR_WAIT} rqp_wr_state_e;
endpackage

//--- rtl/rqp_age_timer.sv
`timescale 1ns/1ns
module rqp_age_timer
  import rqp_pkg::*;
#(
  parameter int TICK_CYC = RQP_AGE_TICK_CYC
) (
  input  wire logic        sys_clk,     // System clock
  input  wire logic        resetn,      // Synchronous reset, active low
  input  wire logic        clk_en,      // Freezes all state when low
  input  wire logic        q_empty,     // Receive queue holds no frame
  output logic      [15:0] age_us       // Microseconds since first frame
);
  logic [$clog2(TICK_CYC)-1:0] div_r;

  // Prescaler down to one-microsecond ticks, held at zero while empty
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      div_r <= '0;
    end else if (clk_en) begin
      if (q_empty || div_r == ($clog2(TICK_CYC))'(TICK_CYC - 1)) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  // Age count saturates so a stale queue never wraps back under the limit
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      age_us <= 16'h0000;
    end else if (clk_en) begin
      if (q_empty) begin
        age_us <= 16'h0000;
      end else if (div_r == ($clog2(TICK_CYC))'(TICK_CYC - 1) && age_us != 16'hffff) begin
        age_us <= age_us + 16'h0001;
      end
    end
  end
endmodule

//--- rtl/rqp_rx_queue_read.sv
`timescale 1ns/1ns
module rqp_rx_queue_read
  import rqp_pkg::*;
#(
  parameter int AGE_TICK_CYC = RQP_AGE_TICK_CYC
) (
  input  wire logic        sys_clk,         // System clock, 250 MHz
  input  wire logic        resetn,          // Synchronous reset, active low
  input  wire logic        clk_en,          // Freezes all state when low
  input  wire logic        host_strobe,     // One-cycle access strobe
  input  wire logic        host_cmd,        // High register access, low data
  input  wire logic        host_we,         // High write, low read
  input  wire logic  [7:0] host_addr,       // Register byte address
  input  wire logic [15:0] host_wdata,      // Write data from host
  input  wire logic  [1:0] host_size,       // Data read width code
  input  wire logic        order_strap,     // Byte-order strap, high forces big endian
  input  wire logic        rx_q_empty,      // Receive queue empty
  input  wire logic [15:0] rx_q_bytes,      // Bytes held in receive queue
  output logic      [15:0] host_rdata,      // Register read data
  output logic             host_rvalid,     // Read data valid pulse
  output logic      [10:0] rx_read_index,   // Byte offset into receive buffer
  output logic             rx_buf_rd,       // Buffer read pulse
  output logic       [1:0] rx_buf_size,     // Width of that buffer read
  output logic             big_endian,      // Effective byte order
  output logic             burst_active,    // Burst data path open
  output logic             rx_irq_flag      // Receive interrupt status flag
);
  logic                rx_ptr_auto_step;
  logic                write_sample_select;
  logic                byte_order_select;
  logic         [15:0] rx_age_limit;
  logic         [15:0] rx_byte_limit;
  logic                age_limit_enable;
  logic                byte_limit_enable;
  logic         [15:0] age_us;
  rqp_wr_state_e       wr_state_r;
  logic          [1:0] wr_cnt_r;
  logic          [7:0] wr_addr_r;
  logic          [1:0] wr_delay;
  logic                wr_take;
  logic                wr_allowed;
  logic                data_rd;
  logic                reg_rd;
  logic                clr_rx_flag;
  logic                age_hit;
  logic                byte_hit;
  logic         [10:0] step;

  // Capture delay after the write strobe
  assign wr_delay = write_sample_select ? 2'(RQP_SAMPLE_FAST_CYC) : 2'(RQP_SAMPLE_SLOW_CYC);

  // Only the queue control register is reachable during a burst
  assign wr_allowed = !burst_active || wr_addr_r == RQP_OFS_QCTRL;
  assign wr_take    = wr_state_r == RQP_WR_WAIT && wr_cnt_r == wr_delay;
  assign data_rd    = host_strobe && !host_cmd && !host_we && burst_active;
  assign reg_rd     = host_strobe && host_cmd && !host_we && wr_state_r == RQP_WR_IDLE;

  // Step size from access width
  always_comb begin
    unique case (host_size)
      RQP_SIZE_BYTE:  step = 11'h001;
      RQP_SIZE_WORD:  step = 11'h002;
      RQP_SIZE_DWORD: step = 11'h004;
      default:        step = 11'h004;
    endcase
  end

  // Write sampler: strobe starts the wait, data is taken after the delay
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_state_r <= RQP_WR_IDLE;
      wr_cnt_r   <= 2'h0;
      wr_addr_r  <= 8'h00;
    end else if (clk_en) begin
      unique case (wr_state_r)
        RQP_WR_IDLE: begin
          if (host_strobe && host_cmd && host_we) begin
            wr_state_r <= RQP_WR_WAIT;
            wr_cnt_r   <= 2'h1;
            wr_addr_r  <= host_addr;
          end
        end
        RQP_WR_WAIT: begin
          if (wr_take) begin
            wr_state_r <= RQP_WR_IDLE;
          end else begin
            wr_cnt_r <= wr_cnt_r + 2'h1;
          end
        end
      endcase
    end
  end

  // Read pointer control fields
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_ptr_auto_step    <= 1'b0;
      write_sample_select <= 1'b0;
      byte_order_select   <= 1'b0;
    end else if (clk_en && wr_take && wr_allowed && wr_addr_r == RQP_OFS_RDPTR) begin
      rx_ptr_auto_step    <= host_wdata[RQP_PTR_AUTO_BIT];
      write_sample_select <= host_wdata[RQP_PTR_SAMPLE_BIT];
      byte_order_select   <= host_wdata[RQP_PTR_ORDER_BIT];
    end
  end

  // Read index: host places it, data reads step it when auto-step is on
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_read_index <= 11'h000;
    end else if (clk_en) begin
      if (wr_take && wr_allowed && wr_addr_r == RQP_OFS_RDPTR) begin
        rx_read_index <= host_wdata[RQP_PTR_IDX_W-1:0];
      end else if (data_rd && rx_ptr_auto_step) begin
        rx_read_index <= rx_read_index + step;
      end
    end
  end

  // Buffer read request toward the queue memory, offset is the post-step index
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_buf_rd   <= 1'b0;
      rx_buf_size <= RQP_SIZE_BYTE;
    end else if (clk_en) begin
      rx_buf_rd <= data_rd;
      if (data_rd) begin
        rx_buf_size <= host_size;
      end
    end
  end

  // Thresholds; age limit is clamped to its legal maximum
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_age_limit  <= RQP_RST_AGE_LIM;
      rx_byte_limit <= RQP_RST_BYTE_LIM;
    end else if (clk_en && wr_take && wr_allowed) begin
      if (wr_addr_r == RQP_OFS_AGE_LIM) begin
        rx_age_limit <= (host_wdata > RQP_AGE_LIM_MAX) ? RQP_AGE_LIM_MAX : host_wdata;
      end
      if (wr_addr_r == RQP_OFS_BYTE_LIM) begin
        rx_byte_limit <= host_wdata;
      end
    end
  end

  // Queue control: threshold enables and burst gate
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      age_limit_enable  <= 1'b0;
      byte_limit_enable <= 1'b0;
      burst_active      <= 1'b0;
    end else if (clk_en && wr_take && wr_addr_r == RQP_OFS_QCTRL) begin
      age_limit_enable  <= host_wdata[RQP_QC_AGE_EN_BIT];
      byte_limit_enable <= host_wdata[RQP_QC_BYTE_EN_BIT];
      burst_active      <= host_wdata[RQP_QC_BURST_BIT];
    end
  end

  // Effective byte order; a high strap overrides the soft bit
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      big_endian <= 1'b0;
    end else if (clk_en) begin
      big_endian <= order_strap ? 1'b1 : byte_order_select;
    end
  end

  rqp_age_timer #(
    .TICK_CYC (AGE_TICK_CYC)
  ) rqp_age_timer_i (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .q_empty (rx_q_empty),
    .age_us  (age_us)
  );

  assign age_hit  = age_limit_enable && !rx_q_empty && age_us > rx_age_limit;
  assign byte_hit = byte_limit_enable && rx_q_bytes > rx_byte_limit;
  assign clr_rx_flag = wr_take && wr_allowed && wr_addr_r == RQP_OFS_IRQ_FLAGS
                       && host_wdata[RQP_IRQ_RX_BIT];

  // Sticky flag; a new event in the clearing cycle keeps it set
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_irq_flag <= 1'b0;
    end else if (clk_en) begin
      if (age_hit || byte_hit) begin
        rx_irq_flag <= 1'b1;
      end else if (clr_rx_flag) begin
        rx_irq_flag <= 1'b0;
      end
    end
  end

  // Register reads; the index and byte-order bit read back as zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      host_rdata  <= 16'h0000;
      host_rvalid <= 1'b0;
    end else if (clk_en) begin
      host_rvalid <= reg_rd;
      if (reg_rd) begin
        host_rdata <= 16'h0000;
        if (host_addr == RQP_OFS_QCTRL) begin
          host_rdata[RQP_QC_AGE_EN_BIT]  <= age_limit_enable;
          host_rdata[RQP_QC_BYTE_EN_BIT] <= byte_limit_enable;
          host_rdata[RQP_QC_BURST_BIT]   <= burst_active;
        end else if (!burst_active) begin
          unique case (host_addr)
            RQP_OFS_RDPTR: begin
              host_rdata[RQP_PTR_AUTO_BIT]   <= rx_ptr_auto_step;
              host_rdata[RQP_PTR_SAMPLE_BIT] <= write_sample_select;
            end
            RQP_OFS_AGE_LIM:   host_rdata <= rx_age_limit;
            RQP_OFS_BYTE_LIM:  host_rdata <= rx_byte_limit;
            RQP_OFS_IRQ_FLAGS: host_rdata[RQP_IRQ_RX_BIT] <= rx_irq_flag;
            default:           host_rdata <= 16'h0000;
          endcase
        end
      end
    end
  end
endmodule

//--- verification/rqp_host_model.sv
`timescale 1ns/1ns
module rqp_host_model (
  input  wire logic        sys_clk,     // Bus clock
  output logic             host_strobe, // Access strobe
  output logic             host_cmd,    // Register access
  output logic             host_we,     // Write
  output logic       [7:0] host_addr,   // Address
  output logic      [15:0] host_wdata,  // Write data
  output logic       [1:0] host_size    // Data width
);
  int hold_cyc = 2; // Edges the write data stands after the strobe edge
  // Idle bus at time zero
  initial begin
    {host_strobe, host_cmd, host_we, host_addr, host_size} = '0;
    host_wdata = 16'hffff;
  end
  // One-cycle strobe; write data stands hold_cyc edges, then is scrambled
  task automatic acc(input logic c, input logic w, input logic [7:0] a,
                     input logic [15:0] d, input logic [1:0] s);
    @(posedge sys_clk) #1;
    {host_strobe, host_cmd, host_we, host_addr, host_wdata, host_size} = {1'b1, c, w, a, d, s};
    @(posedge sys_clk) #1;
    host_strobe = 1'b0;
    if (w) begin
      repeat (hold_cyc) @(posedge sys_clk);
      #1 host_wdata = ~d;
    end
  endtask
endmodule

//--- verification/rqp_rx_queue_read_props.sv
`timescale 1ns/1ns
module rqp_rx_queue_read_props
  import rqp_pkg::*;
#(
  parameter int AGE_TICK_CYC = RQP_AGE_TICK_CYC
) (
  input wire logic        sys_clk,       // Clock
  input wire logic        resetn,        // Reset
  input wire logic        clk_en,        // Clock enable
  input wire logic        host_strobe,   // Strobe
  input wire logic        host_cmd,      // Register access
  input wire logic        host_we,       // Write
  input wire logic  [7:0] host_addr,     // Address
  input wire logic        order_strap,   // Strap
  input wire logic        rx_q_empty,    // Queue empty
  input wire logic [15:0] rx_q_bytes,    // Queue bytes
  input wire logic [15:0] host_rdata,    // Read data
  input wire logic        host_rvalid,   // Read valid
  input wire logic [10:0] rx_read_index, // Index
  input wire logic        rx_buf_rd,     // Buffer read
  input wire logic  [1:0] rx_buf_size,   // Read width
  input wire logic        big_endian,    // Byte order
  input wire logic        burst_active,  // Burst open
  input wire logic        rx_irq_flag    // Receive flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Decoded requests; flag clear lands up to two edges after its strobe
  wire logic dread = clk_en && host_strobe && !host_cmd && !host_we && burst_active;
  wire logic wr92 = host_strobe && host_cmd && host_we && host_addr == RQP_OFS_IRQ_FLAGS;
  sequence s_dread; dread; endsequence
  sequence s_step; rx_buf_rd && rx_read_index != $past(rx_read_index); endsequence
  property p_buf_open; s_dread |=> rx_buf_rd; endproperty
  a_buf_open: assert property (p_buf_open) else $error("data read lost");
  property p_step; s_step |-> rx_read_index - $past(rx_read_index) ==
    (rx_buf_size == 2'h0 ? 11'h1 : rx_buf_size == 2'h1 ? 11'h2 : 11'h4); endproperty
  a_step: assert property (p_step) else $error("bad index step");
  property p_endian; $past(order_strap) && $past(resetn) |-> big_endian; endproperty
  a_endian: assert property (p_endian) else $error("strap ignored");
  property p_sticky; rx_irq_flag && !$past(wr92) && !$past(wr92, 2) |=> rx_irq_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_cause; $rose(rx_irq_flag) |-> $past(rx_q_bytes != 16'h0000 || !rx_q_empty);
  endproperty
  a_cause: assert property (p_cause) else $error("flag without cause");
  property p_ptr_wo; host_rvalid && $past(host_addr) == RQP_OFS_RDPTR |->
    (host_rdata & 16'hafff) == 16'h0000; endproperty
  a_ptr_wo: assert property (p_ptr_wo) else $error("index readable");
  property p_block; host_rvalid && $past(burst_active) && $past(host_addr) != RQP_OFS_QCTRL
    |-> host_rdata == 16'h0000; endproperty
  a_block: assert property (p_block) else $error("register open in burst");
  property p_age_max; host_rvalid && $past(host_addr) == RQP_OFS_AGE_LIM |->
    host_rdata <= RQP_AGE_LIM_MAX; endproperty
  a_age_max: assert property (p_age_max) else $error("age limit too big");
endmodule
bind rqp_rx_queue_read rqp_rx_queue_read_props #(.AGE_TICK_CYC(AGE_TICK_CYC)) rqp_props_i (
  .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .host_strobe(host_strobe),
  .host_cmd(host_cmd),
  .host_we(host_we), .host_addr(host_addr), .order_strap(order_strap),
  .rx_q_empty(rx_q_empty), .rx_q_bytes(rx_q_bytes), .host_rdata(host_rdata),
  .host_rvalid(host_rvalid), .rx_read_index(rx_read_index), .rx_buf_rd(rx_buf_rd),
  .rx_buf_size(rx_buf_size), .big_endian(big_endian), .burst_active(burst_active),
  .rx_irq_flag(rx_irq_flag));

//--- verification/rqp_rx_queue_read_tb.sv
`timescale 1ns/1ns
module rqp_rx_queue_read_tb;
  import rqp_pkg::*;
  logic        sys_clk = 1'b0, resetn = 1'b0, order_strap = 1'b0, rx_q_empty = 1'b1;
  logic        clk_en = 1'b1;
  logic [15:0] rx_q_bytes = 16'h0000, host_wdata, host_rdata;
  logic        host_strobe, host_cmd, host_we, host_rvalid, rx_buf_rd;
  logic        big_endian, burst_active, rx_irq_flag;
  logic  [7:0] host_addr;
  logic [10:0] rx_read_index;
  logic  [1:0] host_size, rx_buf_size;
  int          fail_count = 0, check_count = 0, cyc = 0;
  // Clock and hang guard
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      final_report();
    end
  end
  rqp_host_model host (.sys_clk(sys_clk), .host_strobe(host_strobe), .host_cmd(host_cmd),
    .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata), .host_size(host_size));
  // Short age tick keeps the run brief
  rqp_rx_queue_read #(.AGE_TICK_CYC(4)) rqp_rx_queue_read_i (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .host_strobe(host_strobe),
    .host_cmd(host_cmd), .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_size(host_size), .order_strap(order_strap), .rx_q_empty(rx_q_empty),
    .rx_q_bytes(rx_q_bytes), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .rx_read_index(rx_read_index), .rx_buf_rd(rx_buf_rd), .rx_buf_size(rx_buf_size),
    .big_endian(big_endian), .burst_active(burst_active), .rx_irq_flag(rx_irq_flag));
  // Compare and bus helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.acc(1'b1, 1'b1, a, d, 2'h0);
  endtask
  task automatic rd(input logic [7:0] a);
    host.acc(1'b1, 1'b0, a, 16'h0000, 2'h0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Age limit reset value, write-only index, byte order
  task automatic t_ptr();
    rd(RQP_OFS_AGE_LIM);
    chk(host_rdata, RQP_RST_AGE_LIM);
    wr(RQP_OFS_RDPTR, 16'h7805);
    chk(rx_read_index, 11'h005);
    wt(1); // Byte order output lags its bit by one edge
    chk(big_endian, 1'b1);
    rd(RQP_OFS_RDPTR);
    chk(host_rdata, 16'h5000);
    order_strap = 1'b1;
    wr(RQP_OFS_RDPTR, 16'h0000);
    chk(big_endian, 1'b1);
    order_strap = 1'b0;
    wt(2);
    chk(big_endian, 1'b0);
  endtask
  // Byte threshold: equal does not fire, one more does; flag sticky
  task automatic t_bytes();
    wr(RQP_OFS_BYTE_LIM, 16'h0010);
    wr(RQP_OFS_QCTRL, 16'h0040);
    rx_q_bytes = 16'h0010;
    wt(3);
    chk(rx_irq_flag, 1'b0);
    rx_q_bytes = 16'h0011;
    wt(3);
    chk(rx_irq_flag, 1'b1);
    rx_q_bytes = 16'h0000;
    rd(RQP_OFS_IRQ_FLAGS);
    chk(host_rdata[RQP_IRQ_RX_BIT], 1'b1);
    chk(host_rvalid, 1'b1);
    chk(rx_irq_flag, 1'b1);
    wr(RQP_OFS_IRQ_FLAGS, 16'h2000);
    chk(rx_irq_flag, 1'b0);
  endtask
  // Burst reads with and without auto-step; index zeroed first
  task automatic t_burst();
    logic [10:0] exp [4] = '{11'h001, 11'h003, 11'h007, 11'h00b};
    host.acc(1'b0, 1'b0, 8'h00, 16'h0000, 2'h0);
    chk(rx_buf_rd, 1'b0);
    for (int k = 1; k >= 0; k--) begin
      wr(RQP_OFS_RDPTR, {1'b0, k[0], 14'h0000});
      wr(RQP_OFS_QCTRL, 16'h0008);
      chk(burst_active, 1'b1);
      for (int i = 0; i < 4; i++) begin
        host.acc(1'b0, 1'b0, 8'h00, 16'h0000, 2'(i));
        chk(rx_buf_rd, 1'b1);
        chk(rx_read_index, k ? exp[i] : 11'h000);
      end
      rd(RQP_OFS_BYTE_LIM);
      chk(host_rdata, 16'h0000);
      wr(RQP_OFS_QCTRL, 16'h0000);
    end
  endtask
  // Age threshold, clamp, timer restart on empty queue
  task automatic t_age();
    wr(RQP_OFS_AGE_LIM, 16'hffff);
    rd(RQP_OFS_AGE_LIM);
    chk(host_rdata, RQP_AGE_LIM_MAX);
    wr(RQP_OFS_AGE_LIM, 16'h0003);
    wr(RQP_OFS_QCTRL, 16'h0080);
    for (int r = 0; r < 2; r++) begin
      rx_q_empty = 1'b0;
      wt(8);
      chk(rx_irq_flag, 1'b0);
      for (int i = 0; i < 40 && rx_irq_flag !== 1'b1; i++) wt(1);
      chk(rx_irq_flag, 1'b1);
      rx_q_empty = 1'b1;
      wr(RQP_OFS_IRQ_FLAGS, 16'h2000);
    end
  endtask
  // Write sample delay by select; a low clock enable ignores a write
  task automatic t_sample();
    host.hold_cyc = 1; // Data gone before the slow sample edge
    wr(RQP_OFS_BYTE_LIM, 16'h00f0);
    host.hold_cyc = 2;
    wr(RQP_OFS_RDPTR, 16'h1000);
    host.hold_cyc = 1; // Fast select still catches it
    wr(RQP_OFS_AGE_LIM, 16'h0123);
    host.hold_cyc = 2;
    wr(RQP_OFS_RDPTR, 16'h0000);
    rd(RQP_OFS_BYTE_LIM);
    chk(host_rdata, 16'hff0f);
    rd(RQP_OFS_AGE_LIM);
    chk(host_rdata, 16'h0123);
    clk_en = 1'b0;
    wr(RQP_OFS_AGE_LIM, 16'h0456);
    clk_en = 1'b1;
    rd(RQP_OFS_AGE_LIM);
    chk(host_rdata, 16'h0123);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence after a 16-cycle reset
  initial begin
    wt(16);
    resetn = 1'b1;
    t_ptr();
    t_sample();
    t_bytes();
    t_burst();
    t_age();
    final_report();
  end
endmodule
